/* File: src/udesu_pkg.sv */
package udesu_pkg;
   // command codes
   localparam logic [7:0] CMD_STATUS_FIRST = 8'ha0;
   localparam logic [7:0] CMD_STATUS_LAST = 8'haf;
   localparam logic [7:0] CMD_UNLOCK = 8'hb0;
   // guard key, high and low byte
   localparam logic [7:0] GUARD_KEY_HIGH_BYTE = 8'haa;
   localparam logic [7:0] GUARD_KEY_LOW_BYTE = 8'h37;
   localparam logic [15:0] GUARD_KEY = {GUARD_KEY_HIGH_BYTE, GUARD_KEY_LOW_BYTE};
   // endpoint_last_txn_status field positions
   localparam int MISSED_STATUS_FLAG_POS = 7;
   localparam int LAST_TOGGLE_BIT_POS = 6;
   localparam int FAULT_LSB_POS = 1;
   localparam int XFER_SUCCESS_FLAG_POS = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int NUM_EP = 16;
   // transaction fault codes
   localparam logic [3:0] FAULT_NONE = 4'h0;
   localparam logic [3:0] FAULT_PID_ENCODING = 4'h1;
   localparam logic [3:0] FAULT_PID_UNKNOWN = 4'h2;
   localparam logic [3:0] FAULT_UNEXPECTED_PACKET = 4'h3;
   localparam logic [3:0] FAULT_TOKEN_CRC = 4'h4;
   localparam logic [3:0] FAULT_DATA_CRC = 4'h5;
   localparam logic [3:0] FAULT_TIMEOUT = 4'h6;
   localparam logic [3:0] FAULT_BABBLE = 4'h7;
   localparam logic [3:0] FAULT_UNEXPECTED_EOP = 4'h8;
   localparam logic [3:0] FAULT_NAK = 4'h9;
   localparam logic [3:0] FAULT_STALL_SENT = 4'ha;
   localparam logic [3:0] FAULT_OVERFLOW = 4'hb;
   localparam logic [3:0] FAULT_ISO_EMPTY = 4'hc;
   localparam logic [3:0] FAULT_BIT_STUFF = 4'hd;
   localparam logic [3:0] FAULT_SYNC = 4'he;
   localparam logic [3:0] FAULT_WRONG_TOGGLE = 4'hf;

   typedef enum logic [1:0] {
      UDESU_IDLE,
      UDESU_STATUS_WAIT,
      UDESU_KEY_WAIT
   } udesu_phase_e;

   typedef struct packed {
      logic cmd_wr;
      logic data_wr;
      logic data_rd;
      logic [15:0] din;
   } udesu_cmd_s;

   typedef struct packed {
      logic valid;
      logic [3:0] ep;
      logic [3:0] fault;
      logic ok;
      logic toggle;
   } udesu_evt_s;

   typedef struct packed {
      udesu_phase_e phase;
      logic [3:0] ep;
      logic locked;
      logic [NUM_EP-1:0][7:0] stat;
      logic [NUM_EP-1:0] pend;
      logic [15:0] dout;
      logic dout_valid;
      logic drop;
      logic wr_ok;
      logic rd_ok;
   } udesu_state_s;
endpackage

/* File: src/udesu_top.sv */
`timescale 1ns/1ns
`default_nettype none

module udesu_top
   import udesu_pkg::*;
(
   // clock, reset, enable
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // processor command and data port
   input wire udesu_pkg::udesu_cmd_s CMD,
   output logic [15:0] DOUT,
   output logic DOUT_VALID,
   // transaction results from the serial engine
   input wire udesu_pkg::udesu_evt_s EVT,
   output logic DROP_DATA,
   // suspend state and access permission
   input wire logic SUSPEND,
   output logic WR_ALLOW,
   output logic RD_ALLOW
);
   import udesu_pkg::*;

   udesu_state_s s_q;
   udesu_state_s s_d;
   logic [NUM_EP-1:0][7:0] stat_nx;
   logic [NUM_EP-1:0] pend_nx;
   logic status_read;
   logic cmd_is_status;

   // a read is only honoured while unlocked; a denied read clears nothing
   assign status_read = CMD.data_rd && s_q.phase == UDESU_STATUS_WAIT && !s_q.locked;
   assign cmd_is_status = CMD.din[7:0] >= CMD_STATUS_FIRST && CMD.din[7:0] <= CMD_STATUS_LAST;

   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++) begin : g_ep
         logic hit;
         logic rd_hit;
         assign hit = EVT.valid && EVT.ep == 4'(g);
         assign rd_hit = status_read && s_q.ep == 4'(g);
         always_comb begin
            stat_nx[g] = s_q.stat[g];
            pend_nx[g] = s_q.pend[g];
            if (rd_hit) begin
               stat_nx[g][MISSED_STATUS_FLAG_POS] = 1'b0;
               pend_nx[g] = 1'b0;
            end
            // a new event beats a read in the same cycle, so nothing is lost
            if (hit) begin
               stat_nx[g][MISSED_STATUS_FLAG_POS] = s_q.pend[g] && !rd_hit;
               stat_nx[g][5] = 1'b0;
               stat_nx[g][FAULT_LSB_POS +: 4] = EVT.fault;
               stat_nx[g][XFER_SUCCESS_FLAG_POS] = EVT.ok;
               if (EVT.ok) begin
                  stat_nx[g][LAST_TOGGLE_BIT_POS] = EVT.toggle;
               end
               pend_nx[g] = 1'b1;
            end
         end
      end
   endgenerate

   always_comb begin
      s_d = s_q;
      s_d.stat = stat_nx;
      s_d.pend = pend_nx;
      s_d.dout_valid = 1'b0;
      s_d.drop = EVT.valid && EVT.fault == FAULT_WRONG_TOGGLE;
      if (SUSPEND) begin
         s_d.locked = 1'b1;
      end
      if (CMD.cmd_wr) begin
         s_d.phase = UDESU_IDLE;
         if (cmd_is_status) begin
            s_d.phase = UDESU_STATUS_WAIT;
            s_d.ep = CMD.din[3:0];
         end else if (CMD.din[7:0] == CMD_UNLOCK) begin
            s_d.phase = UDESU_KEY_WAIT;
         end
      end else begin
         case (s_q.phase)
            UDESU_STATUS_WAIT: begin
               if (CMD.data_rd) begin
                  s_d.phase = UDESU_IDLE;
                  s_d.dout_valid = 1'b1;
                  s_d.dout = 16'h0000;
                  if (status_read) begin
                     s_d.dout = {8'h00, s_q.stat[s_q.ep]};
                  end
               end
            end
            UDESU_KEY_WAIT: begin
               if (CMD.data_wr) begin
                  s_d.phase = UDESU_IDLE;
                  // the key cannot lift protection while still suspended
                  if (CMD.din == GUARD_KEY && !SUSPEND) begin
                     s_d.locked = 1'b0;
                  end // any other value leaves protection alone
               end
            end
            default: begin
            end
         endcase
      end
      s_d.wr_ok = !s_d.locked && !SUSPEND;
      s_d.rd_ok = !s_d.locked;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s_q.phase <= UDESU_IDLE;
         s_q.ep <= 4'h0;
         s_q.locked <= 1'b0;
         s_q.stat <= {NUM_EP{STATUS_RESET}};
         s_q.pend <= '0;
         s_q.dout <= 16'h0000;
         s_q.dout_valid <= 1'b0;
         s_q.drop <= 1'b0;
         s_q.wr_ok <= 1'b1;
         s_q.rd_ok <= 1'b1;
      end else if (CE) begin
         s_q <= s_d;
      end
   end

   assign DOUT = s_q.dout;
   assign DOUT_VALID = s_q.dout_valid;
   assign DROP_DATA = s_q.drop;
   assign WR_ALLOW = s_q.wr_ok;
   assign RD_ALLOW = s_q.rd_ok;
endmodule

`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import udesu_pkg::*;
   logic CLK = 0, RST_N = 0, CE = 1, SUSPEND = 0;
   udesu_evt_s EVT = '0;
   udesu_cmd_s CMD;
   logic [15:0] DOUT;
   logic DOUT_VALID, DROP_DATA, WR_ALLOW, RD_ALLOW;
   int error_cnt = 0, tests_run = 0;
   always #50 CLK = ~CLK;
   udesu_top i_udesu_top (.CLK, .RST_N, .CE, .CMD, .DOUT, .DOUT_VALID, .EVT, .DROP_DATA,
      .SUSPEND, .WR_ALLOW, .RD_ALLOW);
   udesu_cpu_model cpu (.CLK, .CMD, .DOUT, .DOUT_VALID);
   task automatic chk(input string n, input logic [15:0] s, e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic evt(input logic [3:0] ep, f, input logic ok, t);
      @(posedge CLK) EVT <= {1'b1, ep, f, ok, t};
      @(posedge CLK) EVT <= '0;
   endtask
   task automatic stat(input logic [3:0] ep, input logic [7:0] e);
      logic [15:0] d;
      logic v;
      cpu.rd(CMD_STATUS_FIRST | ep, d, v);
      chk("valid", v, 1);
      chk("status", d, {8'h00, e});
   endtask
   task automatic t_reset();
      for (int i = 0; i < 16; i++)
         stat(i[3:0], 8'h00);
   endtask
   // endpoint n gets fault code n; only endpoint 0 succeeds
   task automatic t_codes();
      for (int f = 0; f < 16; f++) begin
         evt(f[3:0], f[3:0], f == 0, 1'b1);
         #1 chk("drop", DROP_DATA, f == 15);
      end
      for (int f = 0; f < 16; f++)
         stat(f[3:0], {1'b0, f == 0, 1'b0, f[3:0], f == 0});
   endtask
   task automatic t_over();
      evt(4'h3, 4'h0, 1'b1, 1'b1);
      evt(4'h3, 4'h9, 1'b0, 1'b0);
      stat(4'h3, 8'hd2);
      stat(4'h3, 8'h52);
      // an event while the enable is low is lost, status stays as it was
      @(posedge CLK) begin
         CE <= 0;
         EVT <= {1'b1, 4'h3, 4'h5, 1'b0, 1'b0};
      end
      @(posedge CLK) begin
         CE <= 1;
         EVT <= '0;
      end
      stat(4'h3, 8'h52);
   endtask
   task automatic t_lock();
      @(posedge CLK) SUSPEND <= 1;
      @(posedge CLK) SUSPEND <= 0;
      #1 chk("wr", WR_ALLOW, 0);
      stat(4'h3, 8'h00);
      cpu.unlock(16'h0037);
      #1 chk("rd", RD_ALLOW, 0);
      cpu.unlock(GUARD_KEY);
      #1 chk("wr", WR_ALLOW, 1);
      chk("rd", RD_ALLOW, 1);
      stat(4'h3, 8'h52);
   endtask
   initial begin
      repeat (10) @(posedge CLK);
      RST_N <= 1;
      t_reset();
      t_codes();
      t_over();
      t_lock();
      print_verdict();
   end
   initial begin
      #1000000;
      error_cnt++;
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: testbench/udesu_cpu_model.sv */
`timescale 1ns/1ns
`default_nettype none
module udesu_cpu_model
   import udesu_pkg::*;
(
   // clock
   input wire logic CLK,
   // command port
   output var udesu_pkg::udesu_cmd_s CMD,
   input wire logic [15:0] DOUT,
   input wire logic DOUT_VALID
);
   initial CMD = '0;
   // idle data is inverted so a late sample cannot match by luck
   task automatic op(input logic [2:0] s, input logic [15:0] d);
      @(posedge CLK) CMD <= {s, d};
      @(posedge CLK) CMD <= {3'b000, ~d};
   endtask
   task automatic rd(input logic [7:0] code, output logic [15:0] d, output logic v);
      op(3'b100, {8'h00, code});
      op(3'b001, 16'h0000);
      #1 d = DOUT;
      v = DOUT_VALID;
   endtask
   task automatic unlock(input logic [15:0] k);
      op(3'b100, {8'h00, CMD_UNLOCK});
      op(3'b010, k);
   endtask
endmodule
`default_nettype wire

/* File: testbench/udesu_top_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module udesu_chk
   import udesu_pkg::*;
(
   // clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // watched ports
   input wire udesu_pkg::udesu_cmd_s CMD,
   input wire logic [15:0] DOUT,
   input wire logic DOUT_VALID,
   input wire udesu_pkg::udesu_evt_s EVT,
   input wire logic DROP_DATA,
   input wire logic SUSPEND,
   input wire logic WR_ALLOW,
   input wire logic RD_ALLOW
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   wire logic key = CE && CMD.data_wr && CMD.din == GUARD_KEY;
   a_drop_wrong: assert property (CE && EVT.valid && EVT.fault == 4'hf |=> DROP_DATA)
      else $error("no drop");
   a_valid_cause: assert property (DOUT_VALID |-> $past(CE && CMD.data_rd))
      else $error("stray answer");
   a_upper_zero: assert property (DOUT_VALID |-> DOUT[15:8] == 8'h00 && !DOUT[5])
      else $error("bad fixed bits");
   a_lock_susp: assert property (CE && SUSPEND |=> !WR_ALLOW && !RD_ALLOW)
      else $error("no lock");
   a_stay_locked: assert property (!WR_ALLOW && !key |=> !WR_ALLOW)
      else $error("lock lost");
   a_locked_zero: assert property (CE && CMD.data_rd && !RD_ALLOW |=> !DOUT_VALID || !DOUT)
      else $error("locked read leaks");
   a_unlock_ok: assert property (key && !SUSPEND && $past(CMD.cmd_wr && CMD.din[7:0] == CMD_UNLOCK, 2)
      |=> WR_ALLOW && RD_ALLOW)
      else $error("no unlock");
   a_bad_key: assert property (CE && CMD.data_wr && CMD.din != GUARD_KEY && !RD_ALLOW |=> !RD_ALLOW)
      else $error("wrong key unlocked");
   c_drop: cover property (DROP_DATA);
   c_missed: cover property (DOUT_VALID && DOUT[7]);
   c_unlock: cover property ($rose(WR_ALLOW));
endmodule
bind udesu_top udesu_chk i_chk (.CLK, .RST_N, .CE, .CMD, .DOUT, .DOUT_VALID, .EVT, .DROP_DATA,
   .SUSPEND, .WR_ALLOW, .RD_ALLOW);
`default_nettype wire
